// ---- rtl/ifc_top.sv ----
// Interrupt flag collector: flag register, mask, control and wake enables
//
// Contract
// R1: Supply monitor low report sets supply_low_flag, bit 7.
// R2: Writing 7Fh to the flag register clears bit 7.
// R3: Touch scan completion sets touch_scan_done_flag, bit 5.
// R4: Writing DFh or setting touch_scan_start clears touch_scan_done_flag.
// R5: Conversion completion sets conversion_done_flag, bit 4.
// R6: Writing EFh or setting conversion_start clears conversion_done_flag.
// R7: Falling edge on line 2 pin sets bit 2, enable ignored.
// R8: Writing FBh clears ext_line2_edge_flag.
// R9: Pin change on a wake-enabled pin sets pin_change_flag, bit 1.
// R10: Pin change flag sets regardless of its interrupt enable.
// R11: Writing FDh clears pin_change_flag.
// R12: 24-bit timer reaching FFFFFFh sets bit 0.
// R13: Writing FEh clears long_timer_overflow_flag.
// R14: Vectoring to service clears bits 2, 1 and 0.
// R15: Flag write clears only zero-written bits; ones leave flags unchanged.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ifc_top
  import ifc_pkg::*;
#(
  parameter int unsigned PW = PIN_W
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_SUPPLY_LOW,
  input wire logic I_TKS_DONE,
  input wire logic I_CNV_DONE,
  input wire logic I_LINE2_PIN,
  input wire logic [PW-1:0] I_PORT_PINS,
  input wire logic [23:0] I_LTIMER,
  input wire logic I_ACK_EL2,
  input wire logic I_ACK_PCH,
  input wire logic I_ACK_LTO,
  output logic O_TKS_START,
  output logic O_CNV_START,
  output logic O_IRQ
);
  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] mask;
    logic [7:0] ctrl;
    logic [PW-1:0] wake;
    logic [7:0] rdata;
    logic tks_start;
    logic cnv_start;
    logic irq;
  } ifc_top_st_t;

  ifc_top_st_t st_r, st_nxt;
  ifc_bus_t bus;
  ifc_evt_t evt;
  logic line2_s;
  logic supply_low_s;
  logic [PW-1:0] pins_s;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [7:0] irq_src;
  logic [7:0] rd_mux;
  logic flag_wr;
  logic el2_fall_w;
  logic pch_w;
  logic lto_w;

  localparam int unsigned NWAKE = PW / 8;

  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // Pin and analog monitor levels come from outside the clock domain
  // Reset to idle levels: line and pins high, supply monitor low, so no event follows reset
  ifc_sync #(.W(PW + 2), .INIT({1'b1, 1'b0, {PW{1'b1}}})) u_sync (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_d({I_LINE2_PIN, I_SUPPLY_LOW, I_PORT_PINS}),
    .o_q({line2_s, supply_low_s, pins_s})
  );

  ifc_edge #(.PW(PW)) u_edge (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_line2(line2_s),
    .i_pins(pins_s),
    .i_wake_en(st_r.wake),
    .i_ltimer(I_LTIMER),
    .o_el2_fall(el2_fall_w),
    .o_pin_change(pch_w),
    .o_lto_hit(lto_w)
  );

  // One driver for the whole carrier; edge outputs land in plain nets first
  assign evt = '{supply_low: supply_low_s, tks_done: I_TKS_DONE, cnv_done: I_CNV_DONE,
                 el2_fall: el2_fall_w, pin_change: pch_w, lto_hit: lto_w};

  assign flag_wr = bus.wr && (bus.addr == ADR_FLAG);

  always_comb begin
    set_v = 8'h00;
    set_v[BIT_LOW] = evt.supply_low; // see R1
    set_v[BIT_TKS] = evt.tks_done; // see R3
    set_v[BIT_CNV] = evt.cnv_done; // see R5
    set_v[BIT_EL2] = evt.el2_fall; // see R7
    set_v[BIT_PCH] = evt.pin_change; // see R9 R10
    set_v[BIT_LTO] = evt.lto_hit; // see R12
  end

  always_comb begin
    clr_v = 8'h00;
    if (flag_wr) begin
      // Zero bits clear, one bits leave the flag alone
      clr_v = ~bus.wdata; // see R2 R4 R6 R8 R11 R13 R15
    end
    if (st_r.tks_start) begin
      clr_v[BIT_TKS] = 1'b1; // see R4
    end
    if (st_r.cnv_start) begin
      clr_v[BIT_CNV] = 1'b1; // see R6
    end
    // Service entry acknowledges only the three auto-cleared flags
    clr_v[BIT_EL2] = clr_v[BIT_EL2] | I_ACK_EL2; // see R14
    clr_v[BIT_PCH] = clr_v[BIT_PCH] | I_ACK_PCH; // see R14
    clr_v[BIT_LTO] = clr_v[BIT_LTO] | I_ACK_LTO; // see R14
  end

  // Line 2 and pin change requests gated by their enables; flags are not
  always_comb begin
    irq_src = st_r.flag & st_r.mask;
    irq_src[BIT_EL2] = irq_src[BIT_EL2] & st_r.ctrl[CTRL_EL2_EN];
    irq_src[BIT_PCH] = irq_src[BIT_PCH] & st_r.ctrl[CTRL_PCH_EN]; // see R10
  end

  always_comb begin
    rd_mux = 8'h00;
    case (bus.addr)
      ADR_FLAG: rd_mux = st_r.flag;
      ADR_MASK: rd_mux = st_r.mask;
      ADR_CTRL: rd_mux = st_r.ctrl;
      default: begin
        for (int k = 0; k < NWAKE; k++) begin
          if (bus.addr == ADR_WAKE0 + 8'(k)) begin
            rd_mux = st_r.wake[k*8 +: 8];
          end
        end
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    // Set wins over a clear in the same cycle
    st_nxt.flag = ((st_r.flag & ~clr_v) | set_v) & FLAG_IMPL;
    st_nxt.tks_start = 1'b0;
    st_nxt.cnv_start = 1'b0;
    st_nxt.rdata = bus.rd ? rd_mux : 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        ADR_MASK: st_nxt.mask = bus.wdata & FLAG_IMPL;
        ADR_CTRL: begin
          // Start bits are self-clearing strobes
          st_nxt.ctrl = bus.wdata & 8'h0C;
          st_nxt.tks_start = bus.wdata[CTRL_TKS_START];
          st_nxt.cnv_start = bus.wdata[CTRL_CNV_START];
        end
        default: begin
          for (int k = 0; k < NWAKE; k++) begin
            if (bus.addr == ADR_WAKE0 + 8'(k)) begin
              st_nxt.wake[k*8 +: 8] = bus.wdata;
            end
          end
        end
      endcase
    end
    st_nxt.irq = |irq_src;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      st_r <= '{flag: FLAG_RST, mask: MASK_RST, ctrl: CTRL_RST, wake: '0,
                rdata: 8'h00, tks_start: 1'b0, cnv_start: 1'b0, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_RDATA = st_r.rdata;
  assign O_TKS_START = st_r.tks_start;
  assign O_CNV_START = st_r.cnv_start;
  assign O_IRQ = st_r.irq;

  sequence s_flag_write(int b);
    flag_wr && !bus.wdata[b] && !set_v[b];
  endsequence

  sequence s_ctrl_start(int b);
    bus.wr && bus.addr == ADR_CTRL && bus.wdata[b];
  endsequence

  // Hardware clears that would hide a broken software write
  sequence s_no_hw_clear;
    !I_ACK_EL2 && !I_ACK_PCH && !I_ACK_LTO && !st_r.tks_start && !st_r.cnv_start;
  endsequence

  a_low_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R1
    evt.supply_low |=> st_r.flag[BIT_LOW])
    else $error("supply low flag not set");
  a_low_level: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R1
    supply_low_s |=> st_r.flag[BIT_LOW])
    else $error("supply low level did not hold the flag");
  a_low_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R2
    flag_wr && bus.wdata == 8'h7F && !evt.supply_low |=> !st_r.flag[BIT_LOW])
    else $error("supply low flag not cleared");

  a_tks_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R3
    I_TKS_DONE |=> st_r.flag[BIT_TKS])
    else $error("touch done flag not set");
  a_tks_start_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R4
    bus.wr && bus.addr == ADR_CTRL && bus.wdata[CTRL_TKS_START] ##1 !I_TKS_DONE
      |=> !st_r.flag[BIT_TKS])
    else $error("touch start did not clear flag");
  a_tks_start_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R4
    s_ctrl_start(CTRL_TKS_START) |=> O_TKS_START)
    else $error("touch start strobe missing");
  a_tks_sw_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R4
    s_flag_write(BIT_TKS) |=> !st_r.flag[BIT_TKS])
    else $error("write zero did not clear touch flag");

  a_cnv_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R5
    I_CNV_DONE |=> st_r.flag[BIT_CNV])
    else $error("conversion flag not set");
  a_cnv_start_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R6
    bus.wr && bus.addr == ADR_CTRL && bus.wdata[CTRL_CNV_START] ##1 !I_CNV_DONE
      |=> !st_r.flag[BIT_CNV])
    else $error("conversion start did not clear flag");
  a_cnv_start_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R6
    s_ctrl_start(CTRL_CNV_START) |=> O_CNV_START)
    else $error("conversion start strobe missing");
  a_cnv_sw_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R6
    s_flag_write(BIT_CNV) |=> !st_r.flag[BIT_CNV])
    else $error("write zero did not clear conversion flag");

  a_el2_edge: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R7
    $fell(line2_s) |=> st_r.flag[BIT_EL2])
    else $error("line 2 falling edge missed");
  a_el2_no_en: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R7
    $fell(line2_s) && !st_r.ctrl[CTRL_EL2_EN] |=> st_r.flag[BIT_EL2])
    else $error("line 2 flag held back by its enable");
  a_sw_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R8
    s_flag_write(BIT_EL2) |=> !st_r.flag[BIT_EL2])
    else $error("write zero did not clear flag");

  a_pch_masked: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R9
    $changed(pins_s) && ((pins_s ^ $past(pins_s)) & st_r.wake) == '0 && !I_ACK_PCH
      && !(flag_wr && !bus.wdata[BIT_PCH]) |=> $stable(st_r.flag[BIT_PCH]))
    else $error("pin change flag moved on disabled pin");
  a_pch_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R9
    ((pins_s ^ $past(pins_s)) & st_r.wake) != '0 |=> st_r.flag[BIT_PCH])
    else $error("pin change on enabled pin missed");
  a_pch_no_en: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R10
    ((pins_s ^ $past(pins_s)) & st_r.wake) != '0 && !st_r.ctrl[CTRL_PCH_EN]
      |=> st_r.flag[BIT_PCH])
    else $error("pin change flag held back by its enable");
  a_pch_irq_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R10
    st_r.flag[BIT_PCH] && st_r.mask[BIT_PCH] && !st_r.ctrl[CTRL_PCH_EN]
      && (st_r.flag & st_r.mask & ~(8'h01 << BIT_PCH)) == 8'h00 |=> !O_IRQ)
    else $error("pin change request passed with enable off");
  a_pch_sw_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R11
    s_flag_write(BIT_PCH) |=> !st_r.flag[BIT_PCH])
    else $error("write zero did not clear pin change flag");

  a_lto_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R12
    I_LTIMER == LTIMER_TOP && $past(I_LTIMER) != LTIMER_TOP |=> st_r.flag[BIT_LTO])
    else $error("timer overflow flag not set");
  // A timer parked at the top must not re-set a cleared flag
  a_lto_once: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R12
    $past(I_NRST) && I_LTIMER == LTIMER_TOP && $past(I_LTIMER) == LTIMER_TOP
      && !st_r.flag[BIT_LTO] |=> !st_r.flag[BIT_LTO])
    else $error("timer flag re-set while parked at top");
  a_lto_sw_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R13
    s_flag_write(BIT_LTO) |=> !st_r.flag[BIT_LTO])
    else $error("write zero did not clear timer flag");

  a_ack_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R14
    I_ACK_LTO && !set_v[BIT_LTO] |=> !st_r.flag[BIT_LTO])
    else $error("service entry did not clear flag");
  a_el2_ack_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R14
    I_ACK_EL2 && !set_v[BIT_EL2] |=> !st_r.flag[BIT_EL2])
    else $error("service entry did not clear line 2 flag");
  a_pch_ack_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R14
    I_ACK_PCH && !set_v[BIT_PCH] |=> !st_r.flag[BIT_PCH])
    else $error("service entry did not clear pin change flag");

  a_keep_ones: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R15
    flag_wr && bus.wdata == 8'hFF && !I_ACK_EL2 && !I_ACK_PCH && !I_ACK_LTO
      && !st_r.tks_start && !st_r.cnv_start
      |=> (st_r.flag & $past(st_r.flag)) == $past(st_r.flag))
    else $error("write of ones disturbed flags");
  a_keep_written: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // see R15
    flag_wr ##0 s_no_hw_clear |=>
      ($past(st_r.flag) & $past(bus.wdata) & ~st_r.flag) == 8'h00)
    else $error("flag written as one was cleared");
endmodule // ifc_top
`default_nettype wire

// ---- rtl/ifc_pkg.sv ----
// Package: offsets, field positions, reset values and carriers for the flag collector
package ifc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_W = 32;
  localparam logic [7:0] ADR_FLAG = 8'h95;
  localparam logic [7:0] ADR_MASK = 8'hA0;
  localparam logic [7:0] ADR_CTRL = 8'hA1;
  localparam logic [7:0] ADR_WAKE0 = 8'hA4;
  localparam int unsigned BIT_LOW = 7;
  localparam int unsigned BIT_TKS = 5;
  localparam int unsigned BIT_CNV = 4;
  localparam int unsigned BIT_EL2 = 2;
  localparam int unsigned BIT_PCH = 1;
  localparam int unsigned BIT_LTO = 0;
  localparam int unsigned CTRL_TKS_START = 0;
  localparam int unsigned CTRL_CNV_START = 1;
  localparam int unsigned CTRL_EL2_EN = 2;
  localparam int unsigned CTRL_PCH_EN = 3;
  localparam logic [7:0] FLAG_IMPL = 8'hB7;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [23:0] LTIMER_TOP = 24'hFF_FFFF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ifc_bus_t;

  typedef struct packed {
    logic supply_low;
    logic tks_done;
    logic cnv_done;
    logic el2_fall;
    logic pin_change;
    logic lto_hit;
  } ifc_evt_t;
endpackage : ifc_pkg

// ---- rtl/ifc_sync.sv ----
// Two-flop synchroniser bank for pin-side levels
`timescale 1ns/1ps
`default_nettype none
module ifc_sync
  import ifc_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ifc_sync_st_t;
  ifc_sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end

  // Pins idle high, so reset to INIT avoids a false edge after release
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= {INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.s2;
endmodule // ifc_sync
`default_nettype wire

// ---- rtl/ifc_edge.sv ----
// Event extraction: falling edge on line 2, enabled pin change, timer terminal count
`timescale 1ns/1ps
`default_nettype none
module ifc_edge
  import ifc_pkg::*;
#(
  parameter int unsigned PW = PIN_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_line2,
  input wire logic [PW-1:0] i_pins,
  input wire logic [PW-1:0] i_wake_en,
  input wire logic [23:0] i_ltimer,
  output logic o_el2_fall,
  output logic o_pin_change,
  output logic o_lto_hit
);
  typedef struct packed {
    logic line2;
    logic [PW-1:0] pins;
    logic at_top;
  } ifc_edge_st_t;
  ifc_edge_st_t st_r, st_nxt;

  always_comb begin
    st_nxt.line2 = i_line2;
    st_nxt.pins = i_pins;
    st_nxt.at_top = (i_ltimer == LTIMER_TOP);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= '{line2: 1'b1, pins: '1, at_top: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Enable line ignored here on purpose: flag sets regardless
  assign o_el2_fall = st_r.line2 & ~i_line2; // see R7
  // Only pins with wake enable contribute
  assign o_pin_change = |((st_r.pins ^ i_pins) & i_wake_en); // see R9
  // One pulse on arrival at the top count, not every cycle held there
  assign o_lto_hit = st_nxt.at_top & ~st_r.at_top; // see R12
endmodule // ifc_edge
`default_nettype wire

// ---- tb/ifc_core_model.sv ----
// Core model: vectors into one service routine on request
`timescale 1ns/1ps
`default_nettype none
module ifc_core_model (
  input wire logic i_clk,
  input wire logic i_irq,
  input wire logic [2:0] i_req,
  output logic o_ack_el2,
  output logic o_ack_pch,
  output logic o_ack_lto
);
  // No vectoring without a pending request, as on a real core
  always_ff @(posedge i_clk) begin
    o_ack_el2 <= i_req[0] & i_irq;
    o_ack_pch <= i_req[1] & i_irq;
    o_ack_lto <= i_req[2] & i_irq;
  end
endmodule // ifc_core_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the flag collector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ifc_pkg::*;
  logic clk, nrst, wr, rd, sl, tks, cnv, l2;
  logic [7:0] addr, wd, rdata;
  logic [31:0] pins;
  logic [23:0] lt;
  logic [2:0] req;
  logic a_el2, a_pch, a_lto, tks_st, cnv_st, irq, st_t, st_c;
  int mismatches = 0;
  int num_checks = 0;
  ifc_top uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_SUPPLY_LOW(sl), .I_TKS_DONE(tks), .I_CNV_DONE(cnv),
    .I_LINE2_PIN(l2), .I_PORT_PINS(pins), .I_LTIMER(lt), .I_ACK_EL2(a_el2),
    .I_ACK_PCH(a_pch), .I_ACK_LTO(a_lto), .O_TKS_START(tks_st), .O_CNV_START(cnv_st),
    .O_IRQ(irq));
  ifc_core_model core (.i_clk(clk), .i_irq(irq), .i_req(req), .o_ack_el2(a_el2),
    .o_ack_pch(a_pch), .o_ack_lto(a_lto));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start pulses stand one cycle, so they are caught right after the write edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    st_t = tks_st;
    st_c = cnv_st;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic ack(input logic [2:0] k);
    @(posedge clk);
    req <= k;
    @(posedge clk);
    req <= 3'b000;
    cyc(2);
  endtask
  task automatic done_pulse;
    @(posedge clk);
    tks <= 1'b1;
    cnv <= 1'b1;
    @(posedge clk);
    tks <= 1'b0;
    cnv <= 1'b0;
    cyc(2);
  endtask
  task automatic t_reset;
    rchk(ADR_FLAG, FLAG_RST);
    rchk(ADR_MASK, MASK_RST);
    rchk(ADR_CTRL, CTRL_RST);
    rchk(ADR_WAKE0, WAKE_RST);
    rchk(8'h50, 8'h00);
  endtask
  task automatic t_supply;
    @(posedge clk);
    sl <= 1'b1;
    cyc(3);
    sl <= 1'b0;
    cyc(4);
    rchk(ADR_FLAG, 8'h80);
    wreg(ADR_FLAG, 8'h7F);
    rchk(ADR_FLAG, 8'h00);
  endtask
  task automatic t_conv;
    done_pulse();
    rchk(ADR_FLAG, 8'h30);
    wreg(ADR_FLAG, 8'hDF);
    rchk(ADR_FLAG, 8'h10);
    wreg(ADR_FLAG, 8'hEF);
    rchk(ADR_FLAG, 8'h00);
    done_pulse();
    wreg(ADR_CTRL, 8'h01);
    chk({7'h00, st_t}, 8'h01);
    rchk(ADR_FLAG, 8'h10);
    wreg(ADR_CTRL, 8'h02);
    chk({7'h00, st_c}, 8'h01);
    rchk(ADR_FLAG, 8'h00);
  endtask
  task automatic t_line2;
    @(posedge clk);
    l2 <= 1'b0;
    cyc(5);
    rchk(ADR_FLAG, 8'h04);
    chk({7'h00, irq}, 8'h00);
    wreg(ADR_FLAG, 8'hFB);
    @(posedge clk);
    l2 <= 1'b1;
    cyc(5);
    rchk(ADR_FLAG, 8'h00);
    @(posedge clk);
    l2 <= 1'b0;
    cyc(5);
    wreg(ADR_MASK, 8'h04);
    wreg(ADR_CTRL, 8'h04);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    ack(3'b001);
    rchk(ADR_FLAG, 8'h00);
  endtask
  task automatic t_pins;
    @(posedge clk);
    pins[0] <= 1'b0;
    cyc(5);
    rchk(ADR_FLAG, 8'h00);
    wreg(ADR_WAKE0, 8'h01);
    @(posedge clk);
    pins[0] <= 1'b1;
    cyc(5);
    rchk(ADR_FLAG, 8'h02);
    wreg(ADR_FLAG, 8'hFD);
    @(posedge clk);
    pins[8] <= 1'b0;
    cyc(5);
    rchk(ADR_FLAG, 8'h00);
    wreg(8'hA5, 8'h01);
    @(posedge clk);
    pins[8] <= 1'b1;
    cyc(5);
    wreg(ADR_MASK, 8'h02);
    wreg(ADR_CTRL, 8'h08);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    ack(3'b010);
    rchk(ADR_FLAG, 8'h00);
  endtask
  task automatic t_timer;
    @(posedge clk);
    lt <= 24'hFF_FFFE;
    cyc(2);
    rchk(ADR_FLAG, 8'h00);
    @(posedge clk);
    lt <= LTIMER_TOP;
    cyc(2);
    rchk(ADR_FLAG, 8'h01);
    // Timer parked at the top must not re-set the flag after the clear
    wreg(ADR_FLAG, 8'hFE);
    rchk(ADR_FLAG, 8'h00);
    @(posedge clk);
    lt <= 24'h00_0000;
    cyc(2);
    lt <= LTIMER_TOP;
    wreg(ADR_MASK, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    ack(3'b100);
    rchk(ADR_FLAG, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    cyc(5000);
    mismatches++;
    stop_test();
  end
  initial begin
    {nrst, wr, rd, sl, tks, cnv} = 6'h00;
    {addr, wd, lt, req} = '0;
    l2 = 1'b1;
    pins = '1;
    cyc(5);
    nrst <= 1'b1;
    t_reset();
    t_supply();
    t_conv();
    t_line2();
    t_pins();
    t_timer();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
